// >>> icm_clk_source.sv
// Partner model: the external sample clock source, seen as per-cycle enables.
// Assumes the block samples the enables on the rising edge of clock_in.
`default_nettype none
module icm_clk_source #(
  parameter int PERIOD = 8
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Control from the bench
  input wire logic run_in,
  input wire logic antiphase_in,
  // Enables towards the block
  output logic main_en_out,
  output logic aux_en_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] LAST = 8'(PERIOD - 1);
  logic [7:0] cnt_r;
  ////////////////////////////////////////////////////////////////////////////////
  // Phase counter; it rests on its last count while stopped, so each burst opens
  // with a main edge one cycle after run rises, where the bench can still see it
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= LAST;
    end else if (!run_in) begin
      cnt_r <= LAST;
    end else begin
      cnt_r <= (cnt_r == LAST) ? 8'h00 : cnt_r + 8'h01;
    end
  end
  // Auxiliary edge only ever in phase or half a period away, never in between
  assign main_en_out = run_in && (cnt_r == 8'h00);
  assign aux_en_out = run_in && (cnt_r == (antiphase_in ? 8'(PERIOD / 2) : 8'h00));
endmodule
`default_nettype wire

// >>> icm_delay_line.sv
// Programmable delay for one core's sampling strobe, counted in system clock cycles.
// Assumes the strobe is a one-cycle pulse spaced further apart than the maximum delay.
`default_nettype none
module icm_delay_line (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Control
  input wire logic bypass_in,
  input wire logic [4:0] delay_in,
  // Strobe
  input wire logic strobe_in,
  output logic strobe_out
);
  import icm_pkg::*;

  typedef struct packed {
    logic busy;
    logic [4:0] count;
  } icm_dly_state_t;

  icm_dly_state_t state_r;
  icm_dly_state_t state_nxt;
  logic fire;

  ////////////////////////////////////////////////////////////////////////////
  // Countdown; a strobe while busy restarts the count (later edge wins).
  // Bypass also drops a pending count, else a strobe left from interleave fires late.
  always_comb begin
    state_nxt = state_r;
    fire = 1'b0;
    if (bypass_in) begin
      state_nxt.busy = 1'b0;
      fire = strobe_in;
    end else if (strobe_in && delay_in == 5'h00) begin
      state_nxt.busy = 1'b0;
      fire = 1'b1;
    end else if (strobe_in) begin
      state_nxt.busy = 1'b1;
      state_nxt.count = delay_in;
    end else if (state_r.busy) begin
      if (state_r.count == ICM_DLY_ONE) begin
        state_nxt.busy = 1'b0;
        fire = 1'b1;
      end
      state_nxt.count = state_r.count - ICM_DLY_ONE;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign strobe_out = fire;
endmodule
`default_nettype wire

// >>> icm_pkg.sv
// Package for the interleave clock mode control block: register map, fields, modes.
// Assumes a single 100 MHz system clock and a register port supplied by the serial slave.
`default_nettype none
package icm_pkg;
  localparam logic [7:0] ICM_ADDR_SAMPLE_MODE = 8'h09;
  localparam logic [7:0] ICM_ADDR_OFFSET_ADJ = 8'h10;
  localparam logic [7:0] ICM_ADDR_FINE_DLY = 8'h37;
  localparam logic [7:0] ICM_ADDR_COARSE_DLY = 8'h38;
  localparam int ICM_SIMUL_BIT = 3;
  localparam logic [7:0] ICM_RST_SAMPLE_MODE = 8'h00;
  localparam logic [7:0] ICM_RST_OFFSET_ADJ = 8'h00;
  localparam logic [7:0] ICM_RST_FINE_DLY = 8'h00;
  localparam logic [7:0] ICM_RST_COARSE_DLY = 8'h00;
  localparam logic [7:0] ICM_ZERO_BYTE = 8'h00;
  // Fine nibble and coarse nibble per core: core 0 low, core 1 high
  localparam int ICM_NIB_W = 4;
  localparam logic [4:0] ICM_DLY_ONE = 5'h01;

  typedef enum logic [2:0] {
    ICM_MODE_INTERLEAVED = 3'b001,
    ICM_MODE_SIMULTANEOUS = 3'b010,
    ICM_MODE_AUX_CLOCK = 3'b100
  } icm_mode_t;

  // Register read/write port
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } icm_reg_req_t;

  // Per-core sample data
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } icm_sample_t;
endpackage
`default_nettype wire

// >>> icm_top.sv
// Interleave clock mode control: core strobes, delay trim, stream merge, output enable.
// Assumes register requests arrive already decoded from the serial port, sync to clock_in.
// The main sample clock is modelled as a per-cycle sample enable; the auxiliary clock
// arrives as a second enable on the same clock.
// Behaviour
// - Resets into interleaved single-channel mode with no register write.
// - Interleaved mode splits main clock into two half-rate strobes 180 degrees apart.
// - Fine delay at 0x37 and coarse at 0x38 add delay per core in interleaved mode only.
// - Mode bit 3 of 0x09 set and strap high selects auxiliary clock.
// - With valid phase, output data of both cores are time aligned in simultaneous and auxiliary modes.
// - Mode bit set, strap low: both cores sample together from main clock.
// - Auxiliary mode strobes core 0 on every main edge and core 1 on the auxiliary clock, and bypasses delay trim.
// - Channel offset correction register at 0x10 writable from serial port.
// - Output enable pin high puts both data buses in high impedance.
// - Interleaved results merge into one stream at the full rate.
`default_nettype none
module icm_top (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Register port
  input wire icm_pkg::icm_reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  // Clock pins and strap
  input wire logic main_clk_en_in,
  input wire logic auxiliary_sample_clock_in,
  input wire logic second_clock_strap_in,
  output logic [1:0] core_strobe_out,
  // Core results
  input wire icm_pkg::icm_sample_t core0_in,
  input wire icm_pkg::icm_sample_t core1_in,
  output logic [7:0] offset_adjust_out,
  // Output buses
  input wire logic output_enable_n_in,
  output logic [7:0] bus_a_data_out,
  output logic [7:0] bus_b_data_out,
  output logic bus_valid_out,
  output logic [1:0] bus_oe_out,
  output icm_pkg::icm_mode_t mode_out
);
  import icm_pkg::*;

  typedef struct packed {
    logic [7:0] sample_mode;
    logic [7:0] offset_adj;
    logic [7:0] fine_dly;
    logic [7:0] coarse_dly;
    logic phase;
    logic [7:0] rdata;
    logic [7:0] hold0;
    logic hold0_ok;
    logic [7:0] out_a;
    logic [7:0] out_b;
    logic out_valid;
    logic expect_core1;
  } icm_state_t;

  icm_state_t state_r;
  icm_state_t state_nxt;
  icm_mode_t mode;
  logic [1:0] raw_strobe;
  logic [1:0] dly_strobe;

  // Read mux shared by read path
  function automatic logic [7:0] reg_read(input icm_state_t s, input logic [7:0] a);
    logic [7:0] v;
    v = ICM_ZERO_BYTE;
    if (a == ICM_ADDR_SAMPLE_MODE) begin
      v = s.sample_mode;
    end else if (a == ICM_ADDR_OFFSET_ADJ) begin
      v = s.offset_adj;
    end else if (a == ICM_ADDR_FINE_DLY) begin
      v = s.fine_dly;
    end else if (a == ICM_ADDR_COARSE_DLY) begin
      v = s.coarse_dly;
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Mode from register bit and strap
  always_comb begin
    if (!state_r.sample_mode[ICM_SIMUL_BIT]) begin
      mode = ICM_MODE_INTERLEAVED;
    end else if (second_clock_strap_in) begin
      mode = ICM_MODE_AUX_CLOCK;
    end else begin
      mode = ICM_MODE_SIMULTANEOUS;
    end
  end

  // Core strobes before trim
  always_comb begin
    raw_strobe = 2'b00;
    case (mode)
      ICM_MODE_INTERLEAVED: begin
        // Alternate edges: half rate each, half a period apart
        raw_strobe[0] = main_clk_en_in && !state_r.phase;
        raw_strobe[1] = main_clk_en_in && state_r.phase;
      end
      ICM_MODE_SIMULTANEOUS: begin
        raw_strobe = {2{main_clk_en_in}};
      end
      ICM_MODE_AUX_CLOCK: begin
        // Core 1 follows the auxiliary clock; phase is the source's job
        raw_strobe[0] = main_clk_en_in;
        raw_strobe[1] = auxiliary_sample_clock_in;
      end
      default: begin
        raw_strobe = 2'b00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-core delay trim: fine plus coarse nibble, bypassed outside interleave
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_trim
      logic [4:0] dly;
      assign dly = 5'({1'b0, state_r.fine_dly[gi*ICM_NIB_W +: ICM_NIB_W]})
        + 5'({1'b0, state_r.coarse_dly[gi*ICM_NIB_W +: ICM_NIB_W]});
      icm_delay_line u_dly (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .bypass_in(mode != ICM_MODE_INTERLEAVED),
        .delay_in(dly),
        .strobe_in(raw_strobe[gi]),
        .strobe_out(dly_strobe[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Registers, merge and alignment
  always_comb begin
    state_nxt = state_r;
    state_nxt.out_valid = 1'b0;
    if (main_clk_en_in && mode == ICM_MODE_INTERLEAVED) begin
      state_nxt.phase = !state_r.phase;
    end
    if (reg_req_in.wr_en) begin
      if (reg_req_in.addr == ICM_ADDR_SAMPLE_MODE) begin
        state_nxt.sample_mode = reg_req_in.wdata;
      end else if (reg_req_in.addr == ICM_ADDR_OFFSET_ADJ) begin
        state_nxt.offset_adj = reg_req_in.wdata;
      end else if (reg_req_in.addr == ICM_ADDR_FINE_DLY) begin
        state_nxt.fine_dly = reg_req_in.wdata;
      end else if (reg_req_in.addr == ICM_ADDR_COARSE_DLY) begin
        state_nxt.coarse_dly = reg_req_in.wdata;
      end
    end
    if (reg_req_in.rd_en) begin
      state_nxt.rdata = reg_read(state_r, reg_req_in.addr);
    end
    if (mode == ICM_MODE_INTERLEAVED) begin
      // One stream on bus A, strictly core 0 then core 1; out-of-turn data dropped
      if (core0_in.valid && !state_r.expect_core1) begin
        state_nxt.out_a = core0_in.data;
        state_nxt.out_valid = 1'b1;
        state_nxt.expect_core1 = 1'b1;
      end else if (core1_in.valid && state_r.expect_core1) begin
        state_nxt.out_a = core1_in.data;
        state_nxt.out_valid = 1'b1;
        state_nxt.expect_core1 = 1'b0;
      end
      state_nxt.hold0_ok = 1'b0;
    end else begin
      // Dual output: hold core 0 until core 1 arrives so both buses change together
      state_nxt.expect_core1 = 1'b0;
      if (core0_in.valid && core1_in.valid) begin
        state_nxt.out_a = core0_in.data;
        state_nxt.out_b = core1_in.data;
        state_nxt.out_valid = 1'b1;
        state_nxt.hold0_ok = 1'b0;
      end else if (core1_in.valid && state_r.hold0_ok) begin
        state_nxt.out_a = state_r.hold0;
        state_nxt.out_b = core1_in.data;
        state_nxt.out_valid = 1'b1;
        state_nxt.hold0_ok = 1'b0;
      end else if (core0_in.valid) begin
        state_nxt.hold0 = core0_in.data;
        state_nxt.hold0_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= '0;
      state_r.sample_mode <= ICM_RST_SAMPLE_MODE;
      state_r.offset_adj <= ICM_RST_OFFSET_ADJ;
      state_r.fine_dly <= ICM_RST_FINE_DLY;
      state_r.coarse_dly <= ICM_RST_COARSE_DLY;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; drivers released while the enable pin is high
  assign core_strobe_out = dly_strobe;
  assign reg_rdata_out = state_r.rdata;
  assign offset_adjust_out = state_r.offset_adj;
  assign bus_a_data_out = state_r.out_a;
  assign bus_b_data_out = state_r.out_b;
  assign bus_valid_out = state_r.out_valid;
  assign bus_oe_out = {2{!output_enable_n_in}};
  assign mode_out = mode;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_reset_interleave;
    @(posedge clock_in) disable iff (rst_in)
      $past(rst_in) |-> mode == ICM_MODE_INTERLEAVED
        && state_r.sample_mode == ICM_RST_SAMPLE_MODE;
  endproperty
  a_reset_interleave: assert property (p_reset_interleave) else $error("mode not interleaved");

  property p_alternate;
    @(posedge clock_in) disable iff (rst_in)
      (mode == ICM_MODE_INTERLEAVED && main_clk_en_in && !state_r.phase)
      |-> raw_strobe == 2'b01 ##1 state_r.phase;
  endproperty
  a_alternate: assert property (p_alternate) else $error("strobes not alternating");

  property p_fine_write;
    @(posedge clock_in) disable iff (rst_in)
      reg_req_in.wr_en && reg_req_in.addr == ICM_ADDR_FINE_DLY
      |=> state_r.fine_dly == $past(reg_req_in.wdata);
  endproperty
  a_fine_write: assert property (p_fine_write) else $error("fine delay not stored");

  property p_aux_mode;
    @(posedge clock_in) disable iff (rst_in)
      state_r.sample_mode[ICM_SIMUL_BIT] && second_clock_strap_in
      |-> raw_strobe[1] == auxiliary_sample_clock_in;
  endproperty
  a_aux_mode: assert property (p_aux_mode) else $error("aux clock not used");

  property p_aligned;
    @(posedge clock_in) disable iff (rst_in)
      (mode != ICM_MODE_INTERLEAVED && core0_in.valid && core1_in.valid)
      |=> bus_valid_out && bus_b_data_out == $past(core1_in.data);
  endproperty
  a_aligned: assert property (p_aligned) else $error("dual data not aligned");

  property p_simul;
    @(posedge clock_in) disable iff (rst_in)
      mode == ICM_MODE_SIMULTANEOUS |-> core_strobe_out == {2{main_clk_en_in}};
  endproperty
  a_simul: assert property (p_simul) else $error("cores not simultaneous");

  property p_bypass;
    @(posedge clock_in) disable iff (rst_in)
      mode == ICM_MODE_AUX_CLOCK && $stable(mode) |-> core_strobe_out == raw_strobe;
  endproperty
  a_bypass: assert property (p_bypass) else $error("trim not bypassed");

  property p_offset;
    @(posedge clock_in) disable iff (rst_in)
      reg_req_in.wr_en && reg_req_in.addr == ICM_ADDR_OFFSET_ADJ
      |=> offset_adjust_out == $past(reg_req_in.wdata);
  endproperty
  a_offset: assert property (p_offset) else $error("offset not stored");

  property p_tristate;
    @(posedge clock_in) disable iff (rst_in)
      output_enable_n_in |-> bus_oe_out == 2'b00;
  endproperty
  a_tristate: assert property (p_tristate) else $error("drivers not released");

  property p_order;
    @(posedge clock_in) disable iff (rst_in)
      (mode == ICM_MODE_INTERLEAVED && core0_in.valid && !state_r.expect_core1)
      |=> bus_valid_out && bus_a_data_out == $past(core0_in.data) && state_r.expect_core1;
  endproperty
  a_order: assert property (p_order) else $error("stream order broken");
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the interleave clock mode control block.
// Assumes the clock source model and the design package are compiled first.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import icm_pkg::*;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  icm_reg_req_t req = '0;
  icm_sample_t c0 = '0;
  icm_sample_t c1 = '0;
  logic strap = 1'b0;
  logic oe_n = 1'b0;
  logic run = 1'b0;
  logic anti = 1'b1;
  logic main_en, aux_en, bus_valid;
  logic [1:0] strobe, bus_oe;
  logic [7:0] rdata, off, bus_a, bus_b;
  icm_mode_t mode;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      complete_run();
    end
  end
  icm_clk_source #(.PERIOD(8)) u_src (.clock_in(clock_in), .rst_in(rst_in), .run_in(run),
    .antiphase_in(anti), .main_en_out(main_en), .aux_en_out(aux_en));
  icm_top u_dut (.clock_in(clock_in), .rst_in(rst_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .main_clk_en_in(main_en), .auxiliary_sample_clock_in(aux_en),
    .second_clock_strap_in(strap), .core_strobe_out(strobe), .core0_in(c0), .core1_in(c1),
    .offset_adjust_out(off), .output_enable_n_in(oe_n), .bus_a_data_out(bus_a),
    .bus_b_data_out(bus_b), .bus_valid_out(bus_valid), .bus_oe_out(bus_oe), .mode_out(mode));
  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(negedge clock_in);
    rst_in = 1'b1;
    run = 1'b0;
    strap = 1'b0;
    repeat (5) @(negedge clock_in);
    rst_in = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clock_in);
    req = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock_in);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clock_in);
    req = '0;
    #1 check("read data", rdata, exp);
  endtask
  // Waits for the next main (or auxiliary) edge, sampling mid-cycle
  task automatic wait_edge(input logic aux);
    int i;
    i = 0;
    do begin
      @(negedge clock_in);
      #1 i++;
    end while ((aux ? aux_en : main_en) !== 1'b1 && i < 40);
    check("clock edge seen", {7'h00, aux ? aux_en : main_en}, 8'h01);
  endtask
  task automatic send(input icm_sample_t s0, input icm_sample_t s1);
    @(negedge clock_in);
    c0 = s0;
    c1 = s1;
    @(negedge clock_in);
    c0 = '0;
    c1 = '0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    logic [7:0] addrs [4];
    addrs = '{ICM_ADDR_OFFSET_ADJ, ICM_ADDR_FINE_DLY, ICM_ADDR_COARSE_DLY, ICM_ADDR_SAMPLE_MODE};
    do_reset();
    #1 check("mode after reset", {5'h00, mode}, {5'h00, ICM_MODE_INTERLEAVED});
    for (int k = 0; k < 4; k++) begin
      rd(addrs[k], 8'h00);
      wr(addrs[k], 8'h08 + 8'(k));
      rd(addrs[k], 8'h08 + 8'(k));
    end
    check("offset out", off, 8'h08);
    wr(8'h20, 8'h5A);
    rd(8'h20, 8'h00);
  endtask
  task automatic t_interleave();
    do_reset();
    run = 1'b1;
    for (int k = 0; k < 2; k++) begin
      wait_edge(1'b0);
      check("strobe core0", {6'h00, strobe}, 8'h01);
      wait_edge(1'b0);
      check("strobe core1", {6'h00, strobe}, 8'h02);
    end
  endtask
  task automatic t_delay();
    do_reset();
    wr(ICM_ADDR_FINE_DLY, 8'h03);
    wr(ICM_ADDR_COARSE_DLY, 8'h02);
    run = 1'b1;
    wait_edge(1'b0);
    check("strobe held back", {6'h00, strobe}, 8'h00);
    repeat (5) @(negedge clock_in);
    #1 check("strobe after trim", {6'h00, strobe}, 8'h01);
    wait_edge(1'b0);
    check("core1 untrimmed", {6'h00, strobe}, 8'h02);
  endtask
  task automatic t_aux();
    do_reset();
    wr(ICM_ADDR_FINE_DLY, 8'h33);
    wr(ICM_ADDR_COARSE_DLY, 8'h22);
    strap = 1'b1;
    wr(ICM_ADDR_SAMPLE_MODE, 8'h08);
    #1 check("aux mode", {5'h00, mode}, {5'h00, ICM_MODE_AUX_CLOCK});
    run = 1'b1;
    for (int k = 0; k < 2; k++) begin
      wait_edge(1'b0);
      check("core0 on main", {6'h00, strobe}, 8'h01);
      wait_edge(1'b1);
      check("core1 on aux", {6'h00, strobe}, 8'h02);
    end
    anti = 1'b0;
    wait_edge(1'b1);
    check("aux in phase", {6'h00, strobe}, 8'h03);
  endtask
  task automatic t_simul();
    do_reset();
    wr(ICM_ADDR_SAMPLE_MODE, 8'h08);
    #1 check("simul mode", {5'h00, mode}, {5'h00, ICM_MODE_SIMULTANEOUS});
    run = 1'b1;
    wait_edge(1'b0);
    check("both strobes", {6'h00, strobe}, 8'h03);
    run = 1'b0;
    send('{1'b1, 8'h5A}, '{1'b1, 8'hA5});
    check("pair valid", {7'h00, bus_valid}, 8'h01);
    check("bus a", bus_a, 8'h5A);
    check("bus b", bus_b, 8'hA5);
    send('{1'b1, 8'h11}, '0);
    check("core0 held", {7'h00, bus_valid}, 8'h00);
    send('0, '{1'b1, 8'h22});
    check("late pair", {bus_valid, bus_a[6:0]}, 8'h91);
    check("late bus b", bus_b, 8'h22);
  endtask
  task automatic t_merge();
    do_reset();
    send('{1'b1, 8'h3C}, '0);
    check("first word", {bus_valid, bus_a[6:0]}, 8'hBC);
    send('0, '{1'b1, 8'hC3});
    check("second word", bus_a, 8'hC3);
    send('0, '{1'b1, 8'h77});
    check("out of turn", {7'h00, bus_valid}, 8'h00);
    send('{1'b1, 8'h44}, '0);
    check("third word", {bus_valid, bus_a[6:0]}, 8'hC4);
    @(negedge clock_in);
    oe_n = 1'b1;
    #1 check("released", {6'h00, bus_oe}, 8'h00);
    @(negedge clock_in);
    oe_n = 1'b0;
    #1 check("driven", {6'h00, bus_oe}, 8'h03);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(negedge clock_in);
    rst_in = 1'b0;
    t_regs();
    t_interleave();
    t_delay();
    t_aux();
    t_simul();
    t_merge();
    complete_run();
  end
endmodule
`default_nettype wire
